// ===== core/hbp_pkg.sv
package hbp_pkg;
  // Register byte offsets over APB (printed offsets are not word multiples)
  localparam int HBP_IDX_STATUS0 = 32'h49;
  localparam int HBP_IDX_STATUS1 = 32'h4d;
  localparam logic [11:0] HBP_ADDR_STATUS0 = 12'(HBP_IDX_STATUS0 * 4);
  localparam logic [11:0] HBP_ADDR_STATUS1 = 12'(HBP_IDX_STATUS1 * 4);
  localparam logic [11:0] HBP_ADDR_BUF0 = 12'h120;
  localparam logic [11:0] HBP_ADDR_BUF1 = 12'h130;
  localparam logic [11:0] HBP_ADDR_CTRL = 12'h140;
  localparam logic [11:0] HBP_ADDR_IRQ_STAT = 12'h144;
  localparam logic [11:0] HBP_ADDR_IRQ_MASK = 12'h148;
  // Status field positions
  localparam int HBP_ST_OBF = 0;
  localparam int HBP_ST_IBF = 1;
  localparam int HBP_ST_CMD = 3;
  // Control fields
  localparam int HBP_CTRL_EN = 0;
  localparam int HBP_CTRL_DOUBLE = 1;
  localparam int HBP_CTRL_RWSTYLE = 2;
  // Interrupt status layout: ibf0, obe0, ibf1, obe1
  localparam int HBP_IRQ_IBF0 = 0;
  localparam int HBP_IRQ_OBE0 = 1;
  localparam int HBP_IRQ_IBF1 = 2;
  localparam int HBP_IRQ_OBE1 = 3;
  localparam logic [7:0] HBP_STATUS_RST = 8'h00;
  localparam logic [2:0] HBP_CTRL_RST = 3'h0;
  localparam logic [3:0] HBP_MASK_RST = 4'h0;
endpackage : hbp_pkg

// ===== core/hbp_host_port.sv
// Function
// R1 - Single mode uses only buffer zero
// R2 - Double mode runs both buffers together
// R3 - Channel one pins active only double
// R4 - Output-full pin mirrors output-full flag
// R5 - Input-full pin mirrors input-full flag
// R6 - Host holds chip select low per access
// R7 - Read: addr high status, low buffer
// R8 - Write: addr low data, high command
// R9 - Separate strobe decode, float when deselected
// R10 - Direction plus enable decode, float deselected
// R11 - Capture data at write strobe rise
// R12 - Capture sets input-full flag
// R13 - Input-full set raises interrupt request
// R14 - Address level stored to status bit 3
// R15 - Core buffer read clears input-full
// R16 - Core buffer write sets output-full
// R17 - Host buffer read drives, clears output-full
// R18 - Read strobe rise raises output-empty request
// R19 - Strobes synchronised, requests one-cycle pulses
//
// The implementer's own choice: register access over APB.
module hbp_host_port (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] HOST_CHIP_SELECT_N,
  input wire logic HOST_ADDR_LINE,
  input wire logic HOST_RD_N_OR_DIR,
  input wire logic HOST_WR_N_OR_EN,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic [1:0] OUTPUT_FULL_FLAG,
  output logic [1:0] INPUT_FULL_FLAG,
  output logic [1:0] CH_PIN_FUNC,
  output logic IRQ
);
  import hbp_pkg::*;

  logic [1:0] cs_s1_reg, cs_s2_reg;
  logic a0_s1_reg, a0_s2_reg, rd_s1_reg, rd_s2_reg, wr_s1_reg, wr_s2_reg;
  logic [7:0] d_s1_reg, d_s2_reg;
  logic rd_act_q_reg, wr_act_q_reg;
  logic [1:0] ch_q_reg;
  logic a0_q_reg;
  logic [7:0] in_buf_reg [2];
  logic [7:0] out_buf_reg [2];
  logic [1:0] ibf_reg, obf_reg, cmd_reg;
  logic [2:0] ctrl_reg;
  logic [3:0] irq_stat_reg, irq_mask_reg;
  logic [3:0] ev_pulse;
  logic [1:0] sel_ch;
  logic rd_act, wr_act, host_any;
  logic apb_acc, apb_wr, apb_rd;
  logic [1:0] core_rd_buf, core_wr_buf;

  function automatic logic [7:0] status_byte(input logic ibf, input logic obf,
                                             input logic cmd);
    logic [7:0] s;
    s = HBP_STATUS_RST;
    s[HBP_ST_OBF] = obf;
    s[HBP_ST_IBF] = ibf;
    s[HBP_ST_CMD] = cmd;
    return s;
  endfunction : status_byte

  // Two-stage sync on all host pins
  // R19 strobe synchronisers
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cs_s1_reg <= 2'h3;
      cs_s2_reg <= 2'h3;
      a0_s1_reg <= 1'b0;
      a0_s2_reg <= 1'b0;
      rd_s1_reg <= 1'b1;
      rd_s2_reg <= 1'b1;
      wr_s1_reg <= 1'b1;
      wr_s2_reg <= 1'b1;
      d_s1_reg <= 8'h00;
      d_s2_reg <= 8'h00;
    end
    else
    begin
      cs_s1_reg <= HOST_CHIP_SELECT_N;
      cs_s2_reg <= cs_s1_reg;
      a0_s1_reg <= HOST_ADDR_LINE;
      a0_s2_reg <= a0_s1_reg;
      rd_s1_reg <= HOST_RD_N_OR_DIR;
      rd_s2_reg <= rd_s1_reg;
      wr_s1_reg <= HOST_WR_N_OR_EN;
      wr_s2_reg <= wr_s1_reg;
      d_s1_reg <= HOST_DATA_IN;
      d_s2_reg <= d_s1_reg;
    end
  end

  // Channel 1 ignored unless double mode and port enabled
  always_comb
  begin
    sel_ch = 2'b00;
    if (ctrl_reg[HBP_CTRL_EN])
    begin
      // R1 single buffer only
      sel_ch[0] = !cs_s2_reg[0];
      // R2 second channel
      // R3 channel one gating
      sel_ch[1] = ctrl_reg[HBP_CTRL_DOUBLE] && !cs_s2_reg[1] && cs_s2_reg[0];
    end
    host_any = |sel_ch;
    if (ctrl_reg[HBP_CTRL_RWSTYLE])
    begin
      // R10 direction plus enable
      rd_act = host_any && wr_s2_reg && rd_s2_reg;
      wr_act = host_any && wr_s2_reg && !rd_s2_reg;
    end
    else
    begin
      // R9 separate strobes
      rd_act = host_any && !rd_s2_reg && wr_s2_reg;
      wr_act = host_any && rd_s2_reg && !wr_s2_reg;
    end
  end

  // Remember selected channel for end-of-strobe events
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_act_q_reg <= 1'b0;
      wr_act_q_reg <= 1'b0;
      ch_q_reg <= 2'b00;
      a0_q_reg <= 1'b0;
    end
    else
    begin
      rd_act_q_reg <= rd_act;
      wr_act_q_reg <= wr_act;
      if (host_any)
      begin
        ch_q_reg <= sel_ch;
        a0_q_reg <= a0_s2_reg;
      end
    end
  end

  // R19 single-cycle event pulses
  always_comb
  begin
    ev_pulse = 4'h0;
    // R13 input-full request
    ev_pulse[HBP_IRQ_IBF0] = wr_act_q_reg && !wr_act && ch_q_reg[0];
    ev_pulse[HBP_IRQ_IBF1] = wr_act_q_reg && !wr_act && ch_q_reg[1];
    // R18 output-empty at read end
    ev_pulse[HBP_IRQ_OBE0] = rd_act_q_reg && !rd_act && ch_q_reg[0] && !a0_q_reg;
    ev_pulse[HBP_IRQ_OBE1] = rd_act_q_reg && !rd_act && ch_q_reg[1] && !a0_q_reg;
  end

  // APB: one setup cycle, ready in access with no wait state
  assign apb_acc = PSEL && PENABLE && PREADY;
  assign apb_wr = apb_acc && PWRITE;
  assign apb_rd = apb_acc && !PWRITE;
  assign core_rd_buf = {apb_rd && PADDR == HBP_ADDR_BUF1, apb_rd && PADDR == HBP_ADDR_BUF0};
  assign core_wr_buf = {apb_wr && PADDR == HBP_ADDR_BUF1, apb_wr && PADDR == HBP_ADDR_BUF0};

  // Per-channel buffers and flags
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ibf_reg <= 2'b00;
      obf_reg <= 2'b00;
      cmd_reg <= 2'b00;
      for (int i = 0; i < 2; i++)
      begin
        in_buf_reg[i] <= 8'h00;
        out_buf_reg[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // R15 core read clears
        if (core_rd_buf[i])
          ibf_reg[i] <= 1'b0;
        // R16 core write sets
        if (core_wr_buf[i])
        begin
          out_buf_reg[i] <= PWDATA[7:0];
          obf_reg[i] <= 1'b1;
        end
        // R17 host read clears output-full
        if (rd_act && sel_ch[i] && !a0_s2_reg && !core_wr_buf[i])
          obf_reg[i] <= 1'b0;
        // R11 capture at strobe end; host set wins over core clear
        if (wr_act_q_reg && !wr_act && ch_q_reg[i])
        begin
          in_buf_reg[i] <= d_s2_reg;
          // R12 flag set with capture
          ibf_reg[i] <= 1'b1;
          // R8 command or data
          // R14 address to bit 3
          cmd_reg[i] <= a0_q_reg;
        end
      end
    end
  end

  // Host data bus drive
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      HOST_DATA_OUT <= 8'h00;
      HOST_DATA_OE <= 1'b0;
    end
    else
    begin
      // R9 float when deselected
      HOST_DATA_OE <= rd_act;
      // R7 status or buffer
      if (a0_s2_reg)
        HOST_DATA_OUT <= sel_ch[1] ? status_byte(ibf_reg[1], obf_reg[1], cmd_reg[1])
                                   : status_byte(ibf_reg[0], obf_reg[0], cmd_reg[0]);
      else
        HOST_DATA_OUT <= sel_ch[1] ? out_buf_reg[1] : out_buf_reg[0];
    end
  end

  // Status pins
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      OUTPUT_FULL_FLAG <= 2'b00;
      INPUT_FULL_FLAG <= 2'b00;
      CH_PIN_FUNC <= 2'b00;
    end
    else
    begin
      // R4 output-full mirror
      OUTPUT_FULL_FLAG <= obf_reg;
      // R5 input-full mirror
      INPUT_FULL_FLAG <= ibf_reg;
      // R3 pin function select
      CH_PIN_FUNC <= {ctrl_reg[HBP_CTRL_EN] && ctrl_reg[HBP_CTRL_DOUBLE],
                      ctrl_reg[HBP_CTRL_EN]};
    end
  end

  // Control, interrupt status and mask
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_reg <= HBP_CTRL_RST;
      irq_mask_reg <= HBP_MASK_RST;
      irq_stat_reg <= 4'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      if (apb_wr && PADDR == HBP_ADDR_CTRL)
        ctrl_reg <= PWDATA[2:0];
      if (apb_wr && PADDR == HBP_ADDR_IRQ_MASK)
        irq_mask_reg <= PWDATA[3:0];
      // Set beats write-one clear in same cycle
      irq_stat_reg <= (irq_stat_reg & ~((apb_wr && PADDR == HBP_ADDR_IRQ_STAT) ?
                       PWDATA[3:0] : 4'h0)) | ev_pulse;
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data taken at setup so it stands through access
  // Status sampled one cycle before the access edge
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      if (PSEL && !PENABLE)
      begin
        case (PADDR)
          HBP_ADDR_STATUS0: PRDATA[7:0] <= status_byte(ibf_reg[0], obf_reg[0], cmd_reg[0]);
          HBP_ADDR_STATUS1: PRDATA[7:0] <= status_byte(ibf_reg[1], obf_reg[1], cmd_reg[1]);
          HBP_ADDR_BUF0: PRDATA[7:0] <= in_buf_reg[0];
          HBP_ADDR_BUF1: PRDATA[7:0] <= in_buf_reg[1];
          HBP_ADDR_CTRL: PRDATA[2:0] <= ctrl_reg;
          HBP_ADDR_IRQ_STAT: PRDATA[3:0] <= irq_stat_reg;
          HBP_ADDR_IRQ_MASK: PRDATA[3:0] <= irq_mask_reg;
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // Assertions
  property p_ibf_set;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (wr_act_q_reg && !wr_act && ch_q_reg[0]) |=> ibf_reg[0] && irq_stat_reg[HBP_IRQ_IBF0];
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("input full not set"); // R12

  property p_cmd_bit;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (wr_act_q_reg && !wr_act && ch_q_reg[0]) |=> cmd_reg[0] == $past(a0_q_reg);
  endproperty
  a_cmd_bit: assert property (p_cmd_bit) else $error("command bit wrong"); // R14

  property p_ibf_clr;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (core_rd_buf[0] && !(wr_act_q_reg && !wr_act && ch_q_reg[0])) |=> !ibf_reg[0];
  endproperty
  a_ibf_clr: assert property (p_ibf_clr) else $error("input full not cleared"); // R15

  property p_obf_set;
    @(posedge REF_CLK) disable iff (!ARST_N) core_wr_buf[1] |=> obf_reg[1];
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("output full not set"); // R16

  property p_pin_mirror;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ##1 (OUTPUT_FULL_FLAG == $past(obf_reg)) && (INPUT_FULL_FLAG == $past(ibf_reg));
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("flag pins stale"); // R4

  property p_float;
    @(posedge REF_CLK) disable iff (!ARST_N) !host_any |=> !HOST_DATA_OE;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while deselected"); // R9

  property p_single;
    @(posedge REF_CLK) disable iff (!ARST_N) !ctrl_reg[HBP_CTRL_DOUBLE] |-> !sel_ch[1];
  endproperty
  a_single: assert property (p_single) else $error("channel 1 active in single"); // R1

  sequence s_rd_end;
    rd_act_q_reg && !rd_act && ch_q_reg[0] && !a0_q_reg;
  endsequence
  property p_obe_pulse;
    @(posedge REF_CLK) disable iff (!ARST_N)
      s_rd_end |=> irq_stat_reg[HBP_IRQ_OBE0] ##0 !ev_pulse[HBP_IRQ_OBE0];
  endproperty
  a_obe_pulse: assert property (p_obe_pulse) else $error("output empty request"); // R18

  property p_obf_clr;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (rd_act && sel_ch[0] && !a0_s2_reg && !core_wr_buf[0]) |=> !obf_reg[0];
  endproperty
  a_obf_clr: assert property (p_obf_clr) else $error("output full not cleared"); // R17

  property p_ibf1_set;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (wr_act_q_reg && !wr_act && ch_q_reg[1]) |=> ibf_reg[1] && irq_stat_reg[HBP_IRQ_IBF1];
  endproperty
  a_ibf1_set: assert property (p_ibf1_set) else $error("channel 1 input full not set"); // R2

  property p_ev_pulse;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (ev_pulse != 4'h0) |=> ((ev_pulse & $past(ev_pulse)) == 4'h0);
  endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("request longer than one cycle"); // R19

  property p_pin_func;
    @(posedge REF_CLK) disable iff (!ARST_N)
      1'b1 |=> CH_PIN_FUNC[1] == $past(ctrl_reg[HBP_CTRL_EN] && ctrl_reg[HBP_CTRL_DOUBLE]);
  endproperty
  a_pin_func: assert property (p_pin_func) else $error("channel 1 pin role wrong"); // R3
endmodule : hbp_host_port

// ===== bench/hbp_host_model.sv
module hbp_host_model (
  input wire logic clk,
  input wire logic rw_style,
  output logic [1:0] cs_n,
  output logic addr,
  output logic rd_dir,
  output logic wr_en,
  output logic [7:0] dq_out,
  input wire logic [7:0] dq_in,
  input wire logic dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n = 2'b11;
    addr = 1'b0;
    rd_dir = 1'b1;
    wr_en = 1'b1;
    dq_out = 8'h00;
  end
  // Released bus shows inverse, never a stale byte
  task automatic idle();
    cs_n <= 2'b11;
    rd_dir <= 1'b1;
    wr_en <= ~rw_style;
    dq_out <= ~dq_out;
  endtask : idle
  task automatic xfer(input logic ch, input logic a0, input logic rd, input logic [7:0] wd,
                      output logic [7:0] rdata);
    @(posedge clk);
    cs_n <= ch ? 2'b01 : 2'b10;
    addr <= a0;
    dq_out <= wd;
    rd_dir <= rw_style ? rd : ~rd;
    wr_en <= rw_style ? 1'b1 : rd;
    repeat (6) @(posedge clk);
    rdata = dq_oe ? dq_in : 8'hxx;
    rd_dir <= rw_style ? rd : 1'b1;
    wr_en <= ~rw_style;
    // Data held past strobe end, capture is late
    repeat (4) @(posedge clk);
    idle();
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : hbp_host_model

// ===== bench/tb.sv
module tb import hbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, a0, rdd, wre, oe, irq, rw_style;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0] cs_n, off, ifl, pinf;
  logic [7:0] dqo, dout, bus, d;
  logic [32:0] exp_q[$], got_q[$];
  int err_count, num_checks, cyc;
  assign bus = oe ? dout : dqo;
  hbp_host_port dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HOST_CHIP_SELECT_N(cs_n), .HOST_ADDR_LINE(a0),
    .HOST_RD_N_OR_DIR(rdd), .HOST_WR_N_OR_EN(wre), .HOST_DATA_IN(bus), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(oe), .OUTPUT_FULL_FLAG(off), .INPUT_FULL_FLAG(ifl), .CH_PIN_FUNC(pinf),
    .IRQ(irq));
  hbp_host_model host (.clk(ref_clk), .rw_style(rw_style), .cs_n(cs_n), .addr(a0),
    .rd_dir(rdd), .wr_en(wre), .dq_out(dqo), .dq_in(bus), .dq_oe(oe));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [32:0] st(input logic o, input logic i, input logic c);
    st = '0;
    st[HBP_ST_OBF] = o;
    st[HBP_ST_IBF] = i;
    st[HBP_ST_CMD] = c;
  endfunction : st
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [32:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [32:0] r;
    apb(1'b1, a, wd, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(e, r);
  endtask : rd
  task automatic hw(input logic ch, input logic c, input logic [7:0] wd);
    logic [7:0] x;
    host.xfer(ch, c, 1'b0, wd, x);
  endtask : hw
  task automatic hr(input logic ch, input logic c, input logic [7:0] e);
    logic [7:0] x;
    host.xfer(ch, c, 1'b1, 8'h00, x);
    chk(33'(e), 33'(x));
  endtask : hr
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial
  begin : watch
    logic [32:0] e, g;
    forever
    begin
      @(posedge ref_clk);
      while (got_q.size() != 0)
      begin
        e = exp_q.pop_front();
        g = got_q.pop_front();
        num_checks++;
        if (e !== g)
        begin
          err_count++;
          $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
      end
    end
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    {arst_n, psel, penable, pwrite, rw_style, paddr, pwdata} = '0;
    seed = 32'h622a70ba;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(HBP_ADDR_STATUS0, 33'(HBP_STATUS_RST));
    rd(HBP_ADDR_IRQ_MASK, 33'(HBP_MASK_RST));
    rd(HBP_ADDR_CTRL, 33'(HBP_CTRL_RST));
    rd(12'h1fc, {1'b1, 32'h0});
    wr(HBP_ADDR_CTRL, 32'h1);
    d = rnd();
    hw(1'b0, 1'b0, d);
    rd(HBP_ADDR_STATUS0, st(0, 1, 0));
    chk(33'(2'b01), 33'(ifl));
    rd(HBP_ADDR_IRQ_STAT, 33'b1 << HBP_IRQ_IBF0);
    rd(HBP_ADDR_BUF0, 33'(d));
    rd(HBP_ADDR_STATUS0, st(0, 0, 0));
    hw(1'b0, 1'b1, ~d);
    rd(HBP_ADDR_STATUS0, st(0, 1, 1));
    rd(HBP_ADDR_BUF0, {25'h0, ~d});
    d = rnd();
    wr(HBP_ADDR_BUF0, 32'(d));
    rd(HBP_ADDR_STATUS0, st(1, 0, 1));
    chk(33'(2'b01), 33'(off));
    hr(1'b0, 1'b1, st(1, 0, 1));
    hr(1'b0, 1'b0, d);
    chk(33'(0), 33'(oe));
    rd(HBP_ADDR_STATUS0, st(0, 0, 1));
    rd(HBP_ADDR_IRQ_STAT, 33'h3);
    chk(33'(0), 33'(irq));
    wr(HBP_ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(33'(1), 33'(irq));
    wr(HBP_ADDR_IRQ_STAT, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk(33'(0), 33'(irq));
    hw(1'b1, 1'b0, d);
    rd(HBP_ADDR_STATUS1, st(0, 0, 0));
    chk(33'(2'b01), 33'(pinf));
    wr(HBP_ADDR_CTRL, 32'h7);
    rw_style <= 1'b1;
    @(posedge ref_clk);
    host.idle();
    d = rnd();
    hw(1'b1, 1'b0, d);
    chk(33'(2'b11), 33'(pinf));
    rd(HBP_ADDR_STATUS1, st(0, 1, 0));
    chk(33'(2'b10), 33'(ifl));
    rd(HBP_ADDR_BUF1, 33'(d));
    wr(HBP_ADDR_BUF1, 32'(~d));
    hr(1'b1, 1'b0, ~d);
    rd(HBP_ADDR_IRQ_STAT, 33'hc);
    repeat (2) @(posedge ref_clk);
    conclude();
  end
endmodule : tb
